/* File: rtl/sync_master_rx.sv */
/*
  Synchronous master receive path: shift clock generation, sampling,
  two-entry receive FIFO with ninth-bit shadow, flags and register port.
  Assumes a single core clock, a pin-level data input from another domain
  and software that follows the documented set-up order.
*/
`timescale 1ns/1ps
module sync_master_rx #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Serial link
  input  wire logic       DATA_LINE_IN,
  output logic            SHIFT_CLK_OUT,
  output logic            SHIFT_CLK_OE,
  // Interrupt
  output logic            IRQ
);

  // ==========================================================
  // Request carrier and decode
  sync_rx_pkg::reg_req_t req;
  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_interrupt_control = req.wr && hit(req.addr, sync_rx_pkg::OFS_INTERRUPT_CONTROL);
  wire wr_receive_status_control  = req.wr && hit(req.addr, sync_rx_pkg::OFS_RECEIVE_STATUS_CTRL);
  wire wr_pie    = req.wr && hit(req.addr, sync_rx_pkg::OFS_PERIPHERAL_IRQ_EN);
  wire wr_transmit_status_control  = req.wr && hit(req.addr, sync_rx_pkg::OFS_TRANSMIT_STATUS_CTL);
  wire wr_brg    = req.wr && hit(req.addr, sync_rx_pkg::OFS_BAUD_RATE_DIVISOR);
  wire rd_data   = req.rd && hit(req.addr, sync_rx_pkg::OFS_RECEIVE_DATA);

  // ==========================================================
  // Registers
  logic [7:0] interrupt_control_q, rxctl_q, pie_q, txctl_q, brg_q;
  logic       overrun_q;
  logic [7:0] rdata_q;

  wire port_en    = rxctl_q[sync_rx_pkg::BIT_SERIAL_PORT_EN];
  wire nine_sel   = rxctl_q[sync_rx_pkg::BIT_NINE_BIT_SELECT];
  wire single_en  = rxctl_q[sync_rx_pkg::BIT_SINGLE_RX_EN];
  wire cont_en    = rxctl_q[sync_rx_pkg::BIT_CONT_RX_EN];
  wire master_sel = txctl_q[sync_rx_pkg::BIT_CLOCK_SRC_MASTER];
  wire sync_sel   = txctl_q[sync_rx_pkg::BIT_LOCKSTEP_MODE];
  wire mode_ok    = port_en && master_sel && sync_sel;

  // ==========================================================
  // Input synchroniser
  logic din_s1_q, din_s2_q;
  always_ff @(posedge REF_CLK) begin
    din_s1_q <= DATA_LINE_IN;
    din_s2_q <= din_s1_q;
  end

  // ==========================================================
  // Shift engine
  sync_rx_pkg::rx_state_t state_q, state_d;
  logic [7:0] div_q;
  logic [3:0] bitcnt_q;
  logic [8:0] shreg_q;
  logic       sclk_q, sclk_oe_q;

  wire rx_active  = mode_ok && (cont_en || single_en);
  wire div_done   = (div_q == brg_q);
  wire [3:0] word_len = nine_sel ? 4'd9 : 4'd8;
  // sample where the driven clock falls
  wire fall_edge  = (state_q == sync_rx_pkg::ST_HIGH) && div_done;
  wire last_bit   = fall_edge && (bitcnt_q == word_len - 4'd1);
  wire [8:0] shreg_next = {din_s2_q, shreg_q[8:1]};

  // clock runs only while a word is being taken
  always_comb begin
    state_d = state_q;
    case (state_q)
      sync_rx_pkg::ST_IDLE: begin
        if (rx_active)
          state_d = sync_rx_pkg::ST_LOW;
      end
      sync_rx_pkg::ST_LOW: begin
        if (!rx_active)
          state_d = sync_rx_pkg::ST_IDLE;
        else if (div_done)
          state_d = sync_rx_pkg::ST_HIGH;
      end
      sync_rx_pkg::ST_HIGH: begin
        if (!rx_active)
          state_d = sync_rx_pkg::ST_IDLE;
        else if (div_done)
          state_d = sync_rx_pkg::ST_LOW;
      end
      default: state_d = sync_rx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET || !port_en) begin
      // disabling the port flushes the engine
      state_q   <= sync_rx_pkg::ST_IDLE;
      div_q     <= sync_rx_pkg::RST_DIV_COUNT;
      bitcnt_q  <= sync_rx_pkg::RST_BIT_COUNT;
      shreg_q   <= 9'h000;
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      sclk_q    <= (state_d == sync_rx_pkg::ST_HIGH);
      sclk_oe_q <= mode_ok;
      if (state_q == sync_rx_pkg::ST_IDLE || div_done)
        div_q <= sync_rx_pkg::RST_DIV_COUNT;
      else
        div_q <= div_q + 8'h01;
      if (state_d == sync_rx_pkg::ST_IDLE)
        bitcnt_q <= sync_rx_pkg::RST_BIT_COUNT;
      else if (fall_edge) begin
        shreg_q  <= shreg_next;
        bitcnt_q <= last_bit ? sync_rx_pkg::RST_BIT_COUNT : bitcnt_q + 4'd1;
      end
    end
  end

  // Assemble the finished word, right aligned for eight bit mode
  sync_rx_pkg::rx_word_t done_word;
  assign done_word.data  = nine_sel ? shreg_next[7:0] : shreg_next[8:1];
  assign done_word.ninth = nine_sel ? shreg_next[8] : 1'b0;

  // ==========================================================
  // Receive FIFO
  sync_rx_pkg::rx_word_t fifo_q [FIFO_DEPTH];
  logic [1:0] count_q;
  wire fifo_full  = (count_q == 2'(FIFO_DEPTH));
  wire fifo_empty = (count_q == 2'd0);
  // move only with room and no overrun pending
  wire push       = last_bit && !fifo_full && !overrun_q;
  wire pop        = rd_data && !fifo_empty;
  // third word with full FIFO is dropped
  wire overrun_ev = last_bit && fifo_full && !overrun_q;

  // two-entry queue, head at index zero
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
      wire [1:0] slot = 2'(gi);
      always_ff @(posedge REF_CLK) begin
        if (RESET || !port_en)
          fifo_q[gi] <= '0;
        else if (pop && push && slot == count_q - 2'd1)
          fifo_q[gi] <= done_word;
        else if (pop)
          fifo_q[gi] <= (gi + 1 < FIFO_DEPTH) ? fifo_q[(gi + 1) % FIFO_DEPTH] : '0;
        else if (push && slot == count_q)
          fifo_q[gi] <= done_word;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK) begin
    if (RESET || !port_en)
      count_q <= 2'd0;
    else if (push && !pop)
      count_q <= count_q + 2'd1;
    else if (pop && !push)
      count_q <= count_q - 2'd1;
  end

  // ==========================================================
  // Control registers
  // single word finishing clears its enable when continuous is off
  wire single_done = last_bit && single_en && !cont_en;
  wire cont_clear  = wr_receive_status_control && !req.wdata[sync_rx_pkg::BIT_CONT_RX_EN];

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      interrupt_control_q  <= sync_rx_pkg::RST_INTERRUPT_CONTROL;
      rxctl_q   <= sync_rx_pkg::RST_RECEIVE_CTRL;
      pie_q     <= sync_rx_pkg::RST_IRQ_EN;
      txctl_q   <= sync_rx_pkg::RST_TRANSMIT_CTRL;
      brg_q     <= sync_rx_pkg::RST_BAUD_DIVISOR;
    end else begin
      if (wr_interrupt_control)
        interrupt_control_q <= req.wdata;
      if (wr_pie)
        pie_q <= req.wdata;
      if (wr_transmit_status_control)
        txctl_q <= (req.wdata & sync_rx_pkg::RST_TX_WRITABLE_MASK) | sync_rx_pkg::RST_TRANSMIT_CTRL;
      if (wr_brg)
        brg_q <= req.wdata;
      if (wr_receive_status_control)
        rxctl_q <= {req.wdata[7:4], 4'h0};
      else if (single_done)
        rxctl_q[sync_rx_pkg::BIT_SINGLE_RX_EN] <= 1'b0;
    end
  end

  // Set wins over the clear written in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET || !port_en)
      overrun_q <= 1'b0;
    else if (overrun_ev)
      overrun_q <= 1'b1;
    else if (cont_clear)
      overrun_q <= 1'b0;
  end

  // ==========================================================
  // Read mux
  // flag reflects a non-empty FIFO, no software write path
  wire rx_flag = !fifo_empty;
  // status shows the head entry's ninth bit
  wire [7:0] status_rd = {rxctl_q[7:4], 1'b0, 1'b0, overrun_q, fifo_q[0].ninth};
  wire [7:0] flags_rd  = {2'b00, rx_flag, 5'b00000};
  logic [7:0] rdata_d;
  always_comb begin
    case (req.addr)
      sync_rx_pkg::OFS_INTERRUPT_CONTROL:   rdata_d = interrupt_control_q;
      sync_rx_pkg::OFS_PERIPHERAL_FLAGS:    rdata_d = flags_rd;
      sync_rx_pkg::OFS_RECEIVE_STATUS_CTRL: rdata_d = status_rd;
      sync_rx_pkg::OFS_RECEIVE_DATA:        rdata_d = fifo_q[0].data;
      sync_rx_pkg::OFS_PERIPHERAL_IRQ_EN:   rdata_d = pie_q;
      sync_rx_pkg::OFS_TRANSMIT_STATUS_CTL: rdata_d = txctl_q;
      sync_rx_pkg::OFS_BAUD_RATE_DIVISOR:   rdata_d = brg_q;
      default:                              rdata_d = 8'h00;
    endcase
  end

  // interrupt gated by the receive interrupt enable bit
  wire irq_d = rx_flag && pie_q[sync_rx_pkg::BIT_RECEIVE_IRQ_EN];
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_q <= 8'h00;
      IRQ     <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rdata_d : 8'h00;
      IRQ     <= irq_d;
    end
  end

  assign REG_RDATA     = rdata_q;
  assign SHIFT_CLK_OUT = sclk_q;
  assign SHIFT_CLK_OE  = sclk_oe_q;

  // ==========================================================
  // Assertions
  sequence word_end_s;
    last_bit && !overrun_q;
  endsequence

  push_on_room_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    word_end_s and !fifo_full and !wr_receive_status_control |=> count_q == $past(count_q) + 2'd1 - 2'(pop))
    else $error("finished word not queued");

  overrun_set_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    word_end_s and fifo_full and !wr_receive_status_control |=> overrun_q && count_q == $past(count_q) - 2'(pop))
    else $error("overrun not flagged or word kept");

  overrun_block_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    overrun_q |-> !push)
    else $error("transfer while overrun");

  overrun_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    overrun_q && port_en && !cont_clear |=> overrun_q)
    else $error("overrun cleared itself");

  irq_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push |=> ##1 (IRQ == pie_q[sync_rx_pkg::BIT_RECEIVE_IRQ_EN]) || pop || $past(pop))
    else $error("interrupt not following enable");

  single_stop_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    single_done && !wr_receive_status_control |=> !single_en ##1 state_q == sync_rx_pkg::ST_IDLE)
    else $error("single reception did not stop");

  cont_keep_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    last_bit && cont_en && !wr_receive_status_control |=> state_q != sync_rx_pkg::ST_IDLE)
    else $error("continuous reception stopped");

  sample_fall_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    fall_edge |=> !sclk_q || !rx_active)
    else $error("sample not at falling clock");

  clk_idle_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !rx_active [*2] |-> !sclk_q)
    else $error("shift clock runs while idle");

  port_off_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !port_en |=> count_q == 2'd0 && !overrun_q && state_q == sync_rx_pkg::ST_IDLE)
    else $error("disable did not flush");

  shreg_flush_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !port_en |=> shreg_q == 9'h000 && bitcnt_q == 4'h0)
    else $error("shift register not flushed");

  start_low_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    state_q == sync_rx_pkg::ST_IDLE && rx_active && !wr_receive_status_control |=> state_q == sync_rx_pkg::ST_LOW)
    else $error("reception did not start");

  cont_run_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    cont_en && mode_ok && !wr_receive_status_control && state_q != sync_rx_pkg::ST_IDLE |=> state_q != sync_rx_pkg::ST_IDLE)
    else $error("continuous reception halted");

  // Bit taken is the synchronised line value at the falling edge
  sample_data_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    fall_edge && port_en |=> shreg_q[8] == $past(din_s2_q))
    else $error("wrong bit sampled");

  nine_len_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    fall_edge && nine_sel && bitcnt_q == 4'd7 |-> !last_bit)
    else $error("nine bit word ended early");

  flag_set_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    push && port_en |=> rx_flag)
    else $error("receive flag not set");

  irq_follow_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    rx_flag && pie_q[sync_rx_pkg::BIT_RECEIVE_IRQ_EN] |=> IRQ)
    else $error("interrupt missing");

  irq_mask_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !pie_q[sync_rx_pkg::BIT_RECEIVE_IRQ_EN] |=> !IRQ)
    else $error("masked interrupt raised");

  flag_empty_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    pop && !push && count_q == 2'd1 |=> !rx_flag)
    else $error("flag kept after last read");

  rd_empty_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    rd_data && fifo_empty |=> REG_RDATA == 8'h00)
    else $error("empty read returned data");

  fifo_bound_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    count_q != 2'd3)
    else $error("queue count out of range");

  full_no_push_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    fifo_full |-> !push)
    else $error("push into full queue");

  // Second entry's ninth bit must move up with its word
  ninth_head_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    pop && count_q == 2'd2 && port_en |=> fifo_q[0].ninth == $past(fifo_q[1].ninth))
    else $error("ninth bit not advanced");

  overrun_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    cont_clear && !overrun_ev |=> !overrun_q)
    else $error("overrun not cleared");

  clk_oe_a: assert property (@(posedge REF_CLK) disable iff (RESET)
    !mode_ok |=> !SHIFT_CLK_OE)
    else $error("clock driven outside master mode");

endmodule : sync_master_rx

/* File: rtl/sync_rx_pkg.sv */
/*
  Constants, register map and carrier types for the synchronous master receiver.
  Assumes a byte-wide register port in the core clock domain.
*/
package sync_rx_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_INTERRUPT_CONTROL   = 8'h0b;
  localparam logic [7:0] OFS_PERIPHERAL_FLAGS    = 8'h0c;
  localparam logic [7:0] OFS_RECEIVE_STATUS_CTRL = 8'h18;
  localparam logic [7:0] OFS_RECEIVE_DATA        = 8'h1a;
  localparam logic [7:0] OFS_PERIPHERAL_IRQ_EN   = 8'h8c;
  localparam logic [7:0] OFS_TRANSMIT_STATUS_CTL = 8'h98;
  localparam logic [7:0] OFS_BAUD_RATE_DIVISOR   = 8'h99;

  // ==========================================================
  // Field positions
  localparam int BIT_GLOBAL_IRQ_EN     = 7;
  localparam int BIT_PERIPH_IRQ_EN     = 6;
  localparam int BIT_RECEIVE_FLAG      = 5;
  localparam int BIT_RECEIVE_IRQ_EN    = 5;
  localparam int BIT_SERIAL_PORT_EN    = 7;
  localparam int BIT_NINE_BIT_SELECT   = 6;
  localparam int BIT_SINGLE_RX_EN      = 5;
  localparam int BIT_CONT_RX_EN        = 4;
  localparam int BIT_OVERRUN_ERROR     = 1;
  localparam int BIT_NINTH_RX_BIT      = 0;
  localparam int BIT_CLOCK_SRC_MASTER  = 7;
  localparam int BIT_LOCKSTEP_MODE     = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_RECEIVE_CTRL      = 8'h00;
  localparam logic [7:0] RST_IRQ_EN            = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_CTRL     = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR      = 8'h00;
  localparam logic [7:0] RST_TX_WRITABLE_MASK  = 8'hfd;
  localparam logic [3:0] RST_BIT_COUNT         = 4'h0;
  localparam logic [7:0] RST_DIV_COUNT         = 8'h00;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HIGH  = 2'b01,
    ST_LOW   = 2'b10
  } rx_state_t;

endpackage : sync_rx_pkg

/* File: tb/sync_slave_model.sv */
/*
  Slave model on the far side of the link: sends a list of words, LSB first.
  Assumes the master shift clock idles low and runs low half first.
*/
`timescale 1ns/1ps
module sync_slave_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  input  wire logic       sclk,
  input  wire logic       nine,
  input  wire logic [8:0] words [8],
  output logic            dl
);
  logic       sclk_q = 1'b0;
  logic [3:0] cnt_q  = 4'h0;
  logic [2:0] idx_q  = 3'h0;
  initial dl = 1'b1;
  // ==========================================================
  // Shift out
  always @(posedge clk) begin
    sclk_q <= sclk;
    if (rst) begin
      cnt_q <= 4'h0;
      idx_q <= 3'h0;
    end else if (sclk && !sclk_q) begin
      dl <= words[idx_q][cnt_q];
    end else if (!sclk && sclk_q) begin
      // Hold is over: never leave the sampled bit standing
      dl    <= ~dl;
      cnt_q <= (cnt_q == (nine ? 4'h8 : 4'h7)) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == (nine ? 4'h8 : 4'h7)) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end
endmodule : sync_slave_model

/* File: tb/test_usart_sync_master_rx.sv */
/*
  Self-checking bench for the synchronous master receiver.
  Assumes sync_slave_model on the link and a shift clock divisor of 3.
*/
`timescale 1ns/1ps
module test_usart_sync_master_rx;
  logic        REF_CLK   = 1'b0;
  logic        RESET     = 1'b1;
  logic [7:0]  REG_ADDR  = 8'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic        REG_WR    = 1'b0;
  logic        REG_RD    = 1'b0;
  logic [7:0]  REG_RDATA;
  logic        DATA_LINE_IN;
  logic        SHIFT_CLK_OUT;
  logic        SHIFT_CLK_OE;
  logic        IRQ;
  logic        nine      = 1'b0;
  logic [8:0]  words [8];
  logic [31:0] seed      = 32'h32d3;
  logic [7:0]  rv;
  logic [7:0]  ofs [8]   = '{8'h0b, 8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h55};
  logic [7:0]  rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  int          miscompares  = 0;
  int          total_checks = 0;

  always #25 REF_CLK = ~REF_CLK;

  sync_master_rx uut (.REF_CLK(REF_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DATA_LINE_IN(DATA_LINE_IN),
    .SHIFT_CLK_OUT(SHIFT_CLK_OUT), .SHIFT_CLK_OE(SHIFT_CLK_OE), .IRQ(IRQ));
  sync_slave_model slave (.clk(REF_CLK), .rst(RESET), .sclk(SHIFT_CLK_OUT), .nine(nine),
    .words(words), .dl(DATA_LINE_IN));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] v;
    rd(a, v);
    chk({1'b0, v & m}, {1'b0, e & m});
  endtask : rdchk

  task automatic wait_irq;
    for (int k = 0; k < 400 && IRQ !== 1'b1; k++) @(posedge REF_CLK);
    chk({8'h0, IRQ}, 9'h1);
    if (IRQ !== 1'b1) conclude();
  endtask : wait_irq

  task automatic irq_is(input logic e);
    repeat (2) @(posedge REF_CLK);
    #1 chk({8'h0, IRQ}, {8'h0, e});
  endtask : irq_is

  // Shift clock must stay low for the whole window
  task automatic quiet;
    logic e;
    e = 1'b0;
    repeat (40) begin
      @(posedge REF_CLK);
      #1 e = e | SHIFT_CLK_OUT;
    end
    chk({8'h0, e}, 9'h0);
  endtask : quiet

  // ==========================================================
  // Main sequence
  initial begin
    for (int k = 0; k < 8; k++) begin
      seed     = xorshift(seed);
      words[k] = seed[8:0];
    end
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    for (int k = 0; k < 8; k++) rdchk(ofs[k], rst_v[k], 8'hff);
    wr(8'h55, 8'hff);
    rdchk(8'h55, 8'h00, 8'hff);
    // Set-up order: divisor, mode, port, then interrupts
    wr(8'h99, 8'h03);
    wr(8'h98, 8'h90);
    wr(8'h18, 8'h80);
    wr(8'h8c, 8'h20);
    wr(8'h0b, 8'hc0);
    rdchk(8'h98, 8'h92, 8'hff);
    rdchk(8'h99, 8'h03, 8'hff);
    chk({8'h0, SHIFT_CLK_OE}, 9'h1);
    quiet();
    // Single word, eight bits
    wr(8'h18, 8'ha0);
    wait_irq();
    rdchk(8'h0c, 8'h20, 8'h20);
    rdchk(8'h18, 8'h80, 8'hfe);
    rdchk(8'h1a, words[0][7:0], 8'hff);
    rdchk(8'h0c, 8'h00, 8'h20);
    irq_is(1'b0);
    quiet();
    // Both enables, nine bits: two held, third lost
    nine <= 1'b1;
    wr(8'h18, 8'hf0);
    rv = 8'h00;
    for (int k = 0; k < 300 && rv[1] !== 1'b1; k++) rd(8'h18, rv);
    chk({8'h0, rv[1]}, 9'h1);
    if (rv[1] !== 1'b1) conclude();
    repeat (100) @(posedge REF_CLK);
    rdchk(8'h18, 8'h02, 8'h02);
    wr(8'h18, 8'hc0);
    rdchk(8'h18, {7'h60, words[1][8]}, 8'hff);
    rdchk(8'h1a, words[1][7:0], 8'hff);
    rdchk(8'h18, {7'h60, words[2][8]}, 8'hff);
    rdchk(8'h1a, words[2][7:0], 8'hff);
    rdchk(8'h0c, 8'h00, 8'h20);
    rdchk(8'h1a, 8'h00, 8'hff);
    // Mask, then port disable in mid-stream
    nine <= 1'b0;
    wr(8'h18, 8'h90);
    wait_irq();
    wr(8'h8c, 8'h00);
    irq_is(1'b0);
    wr(8'h8c, 8'h20);
    irq_is(1'b1);
    wr(8'h18, 8'h10);
    rdchk(8'h0c, 8'h00, 8'h20);
    rdchk(8'h18, 8'h00, 8'h02);
    rdchk(8'h1a, 8'h00, 8'hff);
    irq_is(1'b0);
    quiet();
    chk({8'h0, SHIFT_CLK_OE}, 9'h0);
    conclude();
  end
endmodule : test_usart_sync_master_rx
